// ==== sac_seq.sv ====
// Conversion sequencer for a 12-bit successive-approximation converter.
// Assumes an analog front end that samples on sample_o and compares against dac_o.
// Overview of operation
// - Trigger, channel and conversion modes combine freely.
// - Software trigger starts only on start command.
// - Hardware no-wait trigger starts conversion immediately.
// - Wait mode powers up, waits, then converts.
// - Select mode converts one chosen channel.
// - Scan mode converts four consecutive ascending channels.
// - Single mode does one pass then idles.
// - Continuous mode repeats until software stops.
// - Sampling four or eight clocks, four after reset.
// - Four-clock sampling gives sixteen clocks total.
// - Each result is twelve bits.
// - Selector addresses twenty external inputs.
// - Selector also routes references and temperature sensor.
`timescale 1ns/1ps
module sac_seq (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire logic hw_trig_i,
    input wire logic comp_i,
    output logic power_on_o,
    output logic sample_o,
    output logic [4:0] in_sel_o,
    output logic [sac_pkg::RES_W-1:0] dac_o,
    output logic done_o
);
    import sac_pkg::*;

    typedef struct packed {
        logic [5:0] ctrl;
        logic [4:0] chan;
        sac_state_e state;
        logic [4:0] cnt;
        logic [7:0] pwr_cnt;
        logic [1:0] scan_idx;
        logic [RES_W-1:0] result;
        logic [4:0] res_ch;
        logic done_flag;
        logic busy;
        logic trig_prev;
        logic power;
        logic sample;
        logic [4:0] in_sel;
        logic done_pulse;
        logic [31:0] rdata;
    } sac_seq_s;

    sac_seq_s r, next_r;
    logic trig_sync;
    logic comp_sync;
    logic sar_load;
    logic sar_step;
    logic [RES_W-1:0] sar_trial;
    logic [RES_W-1:0] sar_result;

    sac_sync u_trig_sync (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .async_i(hw_trig_i),
        .sync_o(trig_sync)
    );

    // Comparator is a latched stage on mclk_i; a synchroniser would lag each bit decision
    assign comp_sync = comp_i;

    sac_sar u_sar (
        .mclk_i(mclk_i),
        .reset_n_i(reset_n_i),
        .load_i(sar_load),
        .step_i(sar_step),
        .comp_i(comp_sync),
        .trial_o(sar_trial),
        .result_o(sar_result)
    );

    sac_trig_e trig_mode;
    logic scan_mode;
    logic cont_mode;
    logic [4:0] samp_len;
    logic enabled;
    logic trig_edge;
    logic sw_start;
    logic sw_stop;
    logic [4:0] first_ch;
    logic [4:0] cur_ch;

    always_comb begin
        trig_mode = sac_trig_e'(r.ctrl[TRIG_LSB +: 2]);
        scan_mode = r.ctrl[CHSEL_BIT];
        cont_mode = r.ctrl[CONV_BIT];
        samp_len = r.ctrl[SAMP_BIT] ? SAMP_LONG : SAMP_SHORT;
        enabled = r.ctrl[ENA_BIT];
        trig_edge = trig_sync & ~r.trig_prev;
        sw_start = wr_i && (addr_i == ADDR_CMD) && wdata_i[START_BIT];
        sw_stop = wr_i && (addr_i == ADDR_CMD) && wdata_i[STOP_BIT];
        // Scan group clamped so all four channels lie in 0..15
        first_ch = (r.chan > SCAN_MAX_FIRST) ? SCAN_MAX_FIRST : r.chan;
        cur_ch = scan_mode ? (first_ch + {3'b000, r.scan_idx}) : r.chan;
    end

    always_comb begin
        next_r = r;
        sar_load = 1'b0;
        sar_step = 1'b0;
        next_r.done_pulse = 1'b0;
        next_r.trig_prev = trig_sync;
        if (wr_i && addr_i == ADDR_CTRL && !r.busy) begin
            next_r.ctrl = wdata_i[5:0];
        end
        if (wr_i && addr_i == ADDR_CHAN && !r.busy) begin
            // External 0..19 or internal sources; other codes ignored
            if (wdata_i[4:0] <= SEL_TEMP) begin
                next_r.chan = wdata_i[4:0];
            end
        end
        case (r.state)
            SAC_IDLE: begin
                next_r.busy = 1'b0;
                next_r.sample = 1'b0;
                next_r.scan_idx = 2'b00;
                next_r.power = enabled && (trig_mode != SAC_TRIG_HW_WAIT);
                if (enabled) begin
                    if (trig_mode == SAC_TRIG_SW && sw_start) begin
                        next_r.state = SAC_SAMPLE;
                    end else if (trig_mode == SAC_TRIG_HW && trig_edge) begin
                        next_r.state = SAC_SAMPLE;
                    end else if (trig_mode == SAC_TRIG_HW_WAIT && trig_edge) begin
                        next_r.state = SAC_PWRUP;
                        next_r.power = 1'b1;
                        next_r.pwr_cnt = PWR_WAIT_CNT;
                    end
                end
                if (next_r.state == SAC_SAMPLE) begin
                    next_r.busy = 1'b1;
                    next_r.sample = 1'b1;
                    next_r.cnt = samp_len - 5'h01;
                    next_r.in_sel = cur_ch;
                end else if (next_r.state == SAC_PWRUP) begin
                    next_r.busy = 1'b1;
                end
            end
            SAC_PWRUP: begin
                if (r.pwr_cnt <= 8'h01) begin
                    next_r.state = SAC_SAMPLE;
                    next_r.sample = 1'b1;
                    next_r.cnt = samp_len - 5'h01;
                    next_r.in_sel = cur_ch;
                end else begin
                    next_r.pwr_cnt = r.pwr_cnt - 8'h01;
                end
            end
            SAC_SAMPLE: begin
                if (r.cnt == 5'h00) begin
                    next_r.state = SAC_CONVERT;
                    next_r.sample = 1'b0;
                    next_r.cnt = CONV_CLKS - 5'h01;
                    sar_load = 1'b1;
                end else begin
                    next_r.cnt = r.cnt - 5'h01;
                end
            end
            SAC_CONVERT: begin
                sar_step = 1'b1;
                if (r.cnt == 5'h00) begin
                    next_r.state = SAC_DONE;
                end else begin
                    next_r.cnt = r.cnt - 5'h01;
                end
            end
            SAC_DONE: begin
                next_r.result = sar_result;
                next_r.res_ch = r.in_sel;
                next_r.done_flag = 1'b1;
                next_r.done_pulse = 1'b1;
                if (scan_mode && r.scan_idx != 2'(SCAN_LEN - 3'h1)) begin
                    next_r.scan_idx = r.scan_idx + 2'b01;
                    next_r.state = SAC_SAMPLE;
                end else if (cont_mode) begin
                    next_r.scan_idx = 2'b00;
                    next_r.state = SAC_SAMPLE;
                end else begin
                    next_r.state = SAC_IDLE;
                end
                if (next_r.state == SAC_SAMPLE) begin
                    next_r.sample = 1'b1;
                    next_r.cnt = samp_len - 5'h01;
                    next_r.in_sel = scan_mode ? (first_ch + {3'b000, next_r.scan_idx}) : r.chan;
                end
            end
            default: begin
                next_r.state = SAC_IDLE;
            end
        endcase
        // Software stop aborts any pass and returns to idle
        if (sw_stop || !enabled) begin
            next_r.state = SAC_IDLE;
            next_r.sample = 1'b0;
            next_r.busy = 1'b0;
        end
        // Reading status clears done; a new completion wins
        if (rd_i && addr_i == ADDR_STAT && !next_r.done_pulse) begin
            next_r.done_flag = 1'b0;
        end
        next_r.rdata = 32'h0000_0000;
        if (rd_i) begin
            case (addr_i)
                ADDR_CTRL: next_r.rdata = {26'h0, r.ctrl};
                ADDR_CHAN: next_r.rdata = {27'h0, r.chan};
                ADDR_STAT: next_r.rdata = {7'h00, r.res_ch, r.result, 3'h0, r.state,
                                           r.busy, r.done_flag};
                default: next_r.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
            r.ctrl <= CTRL_RESET;
            r.chan <= CHAN_RESET;
            r.state <= SAC_IDLE;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from flops; dac follows the SAR trial register
    assign rdata_o = r.rdata;
    assign power_on_o = r.power;
    assign sample_o = r.sample;
    assign in_sel_o = r.in_sel;
    assign dac_o = sar_trial;
    assign done_o = r.done_pulse;
endmodule // sac_seq

// ==== sac_pkg.sv ====
// Package for the conversion sequencer: register map, fields, timing.
// Assumes a 200 MHz converter clock and a plain address/strobe register port.
package sac_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CHAN = 4'h4;
    localparam logic [3:0] ADDR_CMD = 4'h8;
    localparam logic [3:0] ADDR_STAT = 4'hC;
    // Control register fields
    localparam int TRIG_LSB = 0;
    localparam int CHSEL_BIT = 2;
    localparam int CONV_BIT = 3;
    localparam int SAMP_BIT = 4;
    localparam int ENA_BIT = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [4:0] CHAN_RESET = 5'h00;
    // Command register fields
    localparam int START_BIT = 0;
    localparam int STOP_BIT = 1;
    // Input selector codes beyond the external channels
    localparam logic [4:0] NUM_EXT_CH = 5'h14;
    localparam logic [4:0] SEL_VREF_P = 5'h14;
    localparam logic [4:0] SEL_VREF_N = 5'h15;
    localparam logic [4:0] SEL_VBG = 5'h16;
    localparam logic [4:0] SEL_TEMP = 5'h17;
    localparam logic [4:0] SCAN_MAX_FIRST = 5'h0C;
    localparam logic [2:0] SCAN_LEN = 3'h4;
    localparam int RES_W = 12;
    // Timing: sampling clocks, clocks of the conversion phase, and power-up wait
    localparam logic [4:0] SAMP_SHORT = 5'h04;
    localparam logic [4:0] SAMP_LONG = 5'h08;
    localparam logic [4:0] CONV_CLKS = 5'h0C;
    localparam int unsigned PWR_WAIT_NS = 1000;
    localparam int unsigned PWR_WAIT_CYC = (PWR_WAIT_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] PWR_WAIT_CNT = PWR_WAIT_CYC[7:0];
    typedef enum logic [1:0] {
        SAC_TRIG_SW = 2'b00,
        SAC_TRIG_HW = 2'b01,
        SAC_TRIG_HW_WAIT = 2'b10
    } sac_trig_e;
    typedef enum logic [2:0] {
        SAC_IDLE = 3'b000,
        SAC_PWRUP = 3'b001,
        SAC_SAMPLE = 3'b010,
        SAC_CONVERT = 3'b011,
        SAC_DONE = 3'b100
    } sac_state_e;
endpackage

// ==== sac_sync.sv ====
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is asynchronous to mclk_i.
`timescale 1ns/1ps
module sac_sync (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic async_i,
    output logic sync_o
);
    typedef struct packed {
        logic meta;
        logic sync;
    } sac_sync_s;
    sac_sync_s r, next_r;
    always_comb begin
        next_r.meta = async_i;
        next_r.sync = r.meta;
    end
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign sync_o = r.sync;
endmodule // sac_sync

// ==== sac_sar.sv ====
// Successive-approximation register: one bit decided per clock, MSB first.
// Assumes the comparator output is already synchronised to mclk_i.
`timescale 1ns/1ps
module sac_sar (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic load_i,
    input wire logic step_i,
    input wire logic comp_i,
    output logic [sac_pkg::RES_W-1:0] trial_o,
    output logic [sac_pkg::RES_W-1:0] result_o
);
    import sac_pkg::*;
    typedef struct packed {
        logic [RES_W-1:0] trial;
        logic [RES_W-1:0] bitm;
    } sac_sar_s;
    sac_sar_s r, next_r;
    always_comb begin
        next_r = r;
        if (load_i) begin
            next_r.bitm = {1'b1, {(RES_W-1){1'b0}}};
            next_r.trial = {1'b1, {(RES_W-1){1'b0}}};
        end else if (step_i) begin
            // Keep the bit if input is above trial, then try the next one
            next_r.trial = (comp_i ? r.trial : (r.trial & ~r.bitm)) | (r.bitm >> 1);
            next_r.bitm = r.bitm >> 1;
        end
    end
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end
    assign trial_o = r.trial;
    assign result_o = r.trial;
endmodule // sac_sar

// ==== sac_seq_chk.sv ====
// Port checker for the conversion sequencer.
// Assumes control is rewritten only while the sequencer is idle.
`timescale 1ns/1ps
module sac_seq_chk import sac_pkg::*; (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic hw_trig_i,
    input wire logic power_on_o,
    input wire logic sample_o,
    input wire logic [4:0] in_sel_o,
    input wire logic done_o
);
    logic [5:0] ctrl;
    logic [7:0] pwr_cnt;
    logic start_wr;
    logic stop_wr;
    logic [4:0] stop_age;
    assign start_wr = wr_i && addr_i == ADDR_CMD && wdata_i[START_BIT];
    assign stop_wr = wr_i && addr_i == ADDR_CMD && wdata_i[STOP_BIT];
    // Shadow of control, and cycles spent powered
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl <= CTRL_RESET;
            pwr_cnt <= 8'h00;
            stop_age <= 5'h1F;
        end else begin
            // Cycles since the last stop command, saturating
            if (stop_wr) begin
                stop_age <= 5'h00;
            end else if (stop_age != 5'h1F) begin
                stop_age <= stop_age + 5'h01;
            end
            if (wr_i && addr_i == ADDR_CTRL) ctrl <= wdata_i[5:0];
            if (!power_on_o) pwr_cnt <= 8'h00;
            else if (pwr_cnt != 8'hFF) pwr_cnt <= pwr_cnt + 8'h01;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    property p_done_pulse; done_o |=> !done_o; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");
    property p_samp4; $rose(sample_o) && !ctrl[SAMP_BIT] |-> sample_o[*4] ##1 !sample_o; endproperty
    a_samp4: assert property (p_samp4) else $error("short sampling wrong");
    property p_samp8; $rose(sample_o) && ctrl[SAMP_BIT] |-> sample_o[*8] ##1 !sample_o; endproperty
    a_samp8: assert property (p_samp8) else $error("long sampling wrong");
    // A stop command inside the pass may cut it short
    property p_total16;
        $rose(sample_o) && !ctrl[SAMP_BIT] |-> ##17 (done_o || stop_age < 5'h11);
    endproperty
    a_total16: assert property (p_total16) else $error("conversion length wrong");
    property p_sel_range; in_sel_o <= SEL_TEMP; endproperty
    a_sel_range: assert property (p_sel_range) else $error("selector out of range");
    property p_sel_stable; sample_o && $past(sample_o) |-> $stable(in_sel_o); endproperty
    a_sel_stable: assert property (p_sel_stable) else $error("selector moved");
    property p_hw_wait;
        $rose(sample_o) && ctrl[1:0] == SAC_TRIG_HW_WAIT |-> pwr_cnt >= PWR_WAIT_CNT - 8'h01;
    endproperty
    a_hw_wait: assert property (p_hw_wait) else $error("power wait cut short");
    property p_hw_nowait;
        $rose(hw_trig_i) && ctrl[1:0] == SAC_TRIG_HW && ctrl[ENA_BIT] && !sample_o
            |-> ##[1:6] sample_o;
    endproperty
    a_hw_nowait: assert property (p_hw_nowait) else $error("trigger not taken");
    property p_sw_quiet;
        $rose(sample_o) && ctrl[1:0] == SAC_TRIG_SW && !ctrl[CHSEL_BIT] && !ctrl[CONV_BIT]
            |-> $past(start_wr);
    endproperty
    a_sw_quiet: assert property (p_sw_quiet) else $error("start without command");
    c_scan: cover property ($rose(sample_o) && ctrl[CHSEL_BIT]);
    c_cont: cover property (done_o && ctrl[CONV_BIT]);
    c_wait: cover property ($rose(power_on_o) && ctrl[1:0] == SAC_TRIG_HW_WAIT);
endmodule // sac_seq_chk
bind sac_seq sac_seq_chk u_chk (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .hw_trig_i(hw_trig_i), .power_on_o(power_on_o),
    .sample_o(sample_o), .in_sel_o(in_sel_o), .done_o(done_o));

// ==== sac_fe_model.sv ====
// Behavioural analog front end: sample-and-hold plus comparator.
// Assumes each input sits at a fixed level made from its selector code.
`timescale 1ns/1ps
module sac_fe_model (
    input wire logic mclk_i,
    input wire logic sample_i,
    input wire logic [4:0] in_sel_i,
    input wire logic [sac_pkg::RES_W-1:0] dac_i,
    output logic comp_o
);
    logic [11:0] held = 12'h000;
    // Fresh level captured on every pass
    always @(posedge mclk_i) begin
        if (sample_i) held <= {in_sel_i, 7'h55};
    end
    // Half an LSB above the level, so an equal trial reads as above
    assign comp_o = held >= dac_i;
endmodule // sac_fe_model

// ==== tb_adc_conversion_sequencer.sv ====
// Self-checking bench for the conversion sequencer.
// Assumes the front-end model levels are {channel, 7'h55}.
`timescale 1ns/1ps
module tb_adc_conversion_sequencer;
    import sac_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic hw_trig_i = 1'b0;
    logic [31:0] rdata_o;
    logic comp_i, power_on_o, sample_o, done_o;
    logic [4:0] in_sel_o;
    logic [RES_W-1:0] dac_o;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;
    sac_seq uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .hw_trig_i(hw_trig_i), .comp_i(comp_i),
        .power_on_o(power_on_o), .sample_o(sample_o), .in_sel_o(in_sel_o), .dac_o(dac_o),
        .done_o(done_o));
    sac_fe_model fe (.mclk_i(mclk_i), .sample_i(sample_o), .in_sel_i(in_sel_o),
        .dac_i(dac_o), .comp_o(comp_i));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic complete_run();
        $display("fails %0d checks %0d", n_fail, checks_done);
        if (n_fail == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: expected %h got %h", $time, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic wait_done(input int lim, output int n);
        n = 0;
        do begin
            @(posedge mclk_i);
            #1 n++;
        end while (done_o !== 1'b1 && n < lim);
    endtask
    task automatic stat_chk(input logic [4:0] ch);
        logic [31:0] d;
        rd(ADDR_STAT, d);
        chk({7'h00, ch, ch, 7'h55, 8'h01}, d & 32'h01FFFF01);
    endtask
    task automatic pulse_hw();
        @(posedge mclk_i);
        hw_trig_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        hw_trig_i <= 1'b0;
    endtask
    task automatic t_reset();
        logic [31:0] d;
        rd(ADDR_CTRL, d);
        chk({26'h0, CTRL_RESET}, d);
        rd(ADDR_CHAN, d);
        chk({27'h0, CHAN_RESET}, d);
        rd(4'h2, d);
        chk(32'h0, d);
        wr(ADDR_CHAN, 32'h1F);
        rd(ADDR_CHAN, d);
        chk(32'h0, d);
        $display("test reset done");
    endtask
    task automatic t_sw(input logic [4:0] ch, input logic samp8);
        int n;
        wr(ADDR_CTRL, {26'h0, 1'b1, samp8, 4'h0});
        wr(ADDR_CHAN, {27'h0, ch});
        wait_done(30, n);
        chk(32'h1E, 32'(n));
        wr(ADDR_CMD, 32'h1);
        wait_done(40, n);
        chk(samp8 ? 32'h15 : 32'h11, 32'(n));
        stat_chk(ch);
        wait_done(30, n);
        chk(32'h1E, 32'(n));
        $display("test software channel %0d done", ch);
    endtask
    task automatic t_scan(input logic [1:0] trig, input logic [4:0] ch, input logic [4:0] first);
        int n;
        wr(ADDR_CTRL, {26'h0, 4'h9, trig});
        wr(ADDR_CHAN, {27'h0, ch});
        if (trig == SAC_TRIG_SW) wr(ADDR_CMD, 32'h1);
        else pulse_hw();
        for (int k = 0; k < 4; k++) begin
            wait_done(40, n);
            chk(32'h1, {31'h0, n < 40});
            stat_chk(first + 5'(k));
        end
        wait_done(40, n);
        chk(32'h28, 32'(n));
        $display("test scan done");
    endtask
    task automatic t_cont();
        int n;
        wr(ADDR_CTRL, 32'h28);
        wr(ADDR_CHAN, 32'h7);
        wr(ADDR_CMD, 32'h1);
        repeat (3) begin
            wait_done(40, n);
            chk(32'h1, {31'h0, n < 40});
            stat_chk(5'h07);
        end
        wr(ADDR_CMD, 32'h2);
        repeat (20) @(posedge mclk_i);
        wait_done(60, n);
        chk(32'h3C, 32'(n));
        $display("test continuous done");
    endtask
    task automatic t_wait();
        int n;
        wr(ADDR_CTRL, 32'h22);
        wr(ADDR_CHAN, 32'h3);
        #1;
        chk(32'h0, {31'h0, power_on_o});
        pulse_hw();
        wait_done(400, n);
        chk(32'h1, {31'h0, n >= 200 && n < 400});
        stat_chk(5'h03);
        $display("test wait mode done");
    endtask
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        logic [4:0] chs [7] = '{5'h00, 5'h05, 5'h13, 5'h14, 5'h15, 5'h16, 5'h17};
        repeat (3) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        t_reset();
        foreach (chs[i]) t_sw(chs[i], i == 1);
        t_scan(SAC_TRIG_SW, 5'h02, 5'h02);
        t_scan(SAC_TRIG_HW, 5'h0E, SCAN_MAX_FIRST);
        t_cont();
        t_wait();
        complete_run();
    end
endmodule // tb_adc_conversion_sequencer
